/* File: logic/ccr_console.sv */
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ccr_console import ccr_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] console_switch_word,
  input wire logic store_key,
  input wire logic address_capture_key,
  input wire logic resume_key,
  input wire logic start_key,
  input wire logic halt_toggle,
  input wire logic console_lockout_position,
  input wire logic power_up_restart,
  input wire logic instr_boundary,
  input wire logic trap_pending,
  input wire logic [15:0] next_pc,
  input wire logic bus_done,
  input wire logic bus_nxm,
  input wire logic core_halt,
  output logic [15:0] lights,
  output logic run_light,
  output logic bus_init,
  output logic psw_clear,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic core_go,
  output logic core_step,
  output logic odd_addr_trap,
  output logic bus_req,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata
);

  ccr_state_s s_r;
  ccr_state_s s_nxt;

  logic store_lvl;
  logic capture_lvl;
  logic resume_lvl;
  logic start_lvl;
  logic halt_lvl;
  logic lock_lvl;
  logic store_on;
  logic store_off;
  logic capture_on;
  logic resume_on;
  logic resume_off;
  logic start_on;
  logic start_off;
  logic is_greg;
  logic [15:0] step_addr;

  logic store_agree;
  logic capture_agree;
  logic resume_agree;
  logic start_agree;
  logic halt_agree;
  logic lock_agree;

  logic store_now;
  logic capture_now;
  logic resume_now;
  logic start_now;
  logic halt_now;
  logic lock_now;

  logic [15:0] dep_target;
  logic dep_greg;
  logic [15:0] dep_bus_addr;

  logic may_deposit;
  logic stop_ok;
  logic show_data;

  //////////////////////////////////////////////////////////////////////////////
  // synchronised key levels: a change counts once stages two and three agree
  always_comb begin
    // stage one may still be settling, so only stages two and three are read
    store_agree = s_r.store_sync[1] == s_r.store_sync[2];
    capture_agree = s_r.capture_sync[1] == s_r.capture_sync[2];
    resume_agree = s_r.resume_sync[1] == s_r.resume_sync[2];
    start_agree = s_r.start_sync[1] == s_r.start_sync[2];
    halt_agree = s_r.halt_sync[1] == s_r.halt_sync[2];
    lock_agree = s_r.lock_sync[1] == s_r.lock_sync[2];

    // a level is accepted only once stages two and three agree
    store_now = store_agree ? s_r.store_sync[2] : s_r.key_lvl[KEY_STORE];
    capture_now = capture_agree ? s_r.capture_sync[2] : s_r.key_lvl[KEY_CAPTURE];
    resume_now = resume_agree ? s_r.resume_sync[2] : s_r.key_lvl[KEY_RESUME];
    start_now = start_agree ? s_r.start_sync[2] : s_r.key_lvl[KEY_START];
    halt_now = halt_agree ? s_r.halt_sync[2] : s_r.key_lvl[KEY_HALT];
    lock_now = lock_agree ? s_r.lock_sync[2] : s_r.key_lvl[KEY_LOCK];

    store_lvl = store_now;
    capture_lvl = capture_now;
    resume_lvl = resume_now;
    start_lvl = start_now;
    halt_lvl = halt_now;
    lock_lvl = lock_now;

    // one edge per accepted change, so a bouncing contact gives one operation
    store_on = store_now & ~s_r.key_lvl[KEY_STORE];
    store_off = ~store_now & s_r.key_lvl[KEY_STORE];
    capture_on = capture_now & ~s_r.key_lvl[KEY_CAPTURE];
    resume_on = resume_now & ~s_r.key_lvl[KEY_RESUME];
    resume_off = ~resume_now & s_r.key_lvl[KEY_RESUME];
    start_on = start_now & ~s_r.key_lvl[KEY_START];
    start_off = ~start_now & s_r.key_lvl[KEY_START];

    is_greg = (s_r.console_addr & GREG_MASK) == GREG_BASE;
    // registers sit on byte addresses, memory on word addresses
    step_addr = is_greg ? s_r.console_addr + REG_STEP
                        : (s_r.console_addr & ODD_MASK) + WORD_STEP;

    // first store of a series uses the captured address as it is
    dep_target = s_r.dep_seen ? step_addr : s_r.console_addr;
    dep_greg = (dep_target & GREG_MASK) == GREG_BASE;
    // bit 0 only survives toward the register window
    dep_bus_addr = dep_greg ? dep_target : dep_target & ODD_MASK;

    may_deposit = store_on && !lock_lvl;
    // a pending trap or interrupt is taken before the stop
    stop_ok = instr_boundary && !trap_pending;
    // only a release that follows an accepted store swaps the display
    show_data = store_off && s_r.dep_key_held;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.store_sync = {s_r.store_sync[1:0], store_key};
    s_nxt.capture_sync = {s_r.capture_sync[1:0], address_capture_key};
    s_nxt.resume_sync = {s_r.resume_sync[1:0], resume_key};
    s_nxt.start_sync = {s_r.start_sync[1:0], start_key};
    s_nxt.halt_sync = {s_r.halt_sync[1:0], halt_toggle};
    s_nxt.lock_sync = {s_r.lock_sync[1:0], console_lockout_position};

    s_nxt.key_lvl[KEY_STORE] = store_now;
    s_nxt.key_lvl[KEY_CAPTURE] = capture_now;
    s_nxt.key_lvl[KEY_RESUME] = resume_now;
    s_nxt.key_lvl[KEY_START] = start_now;
    s_nxt.key_lvl[KEY_HALT] = halt_now;
    s_nxt.key_lvl[KEY_LOCK] = lock_now;

    s_nxt.go = 1'b0;
    s_nxt.step = 1'b0;
    s_nxt.odd_trap = 1'b0;
    s_nxt.psw_clear = 1'b0;
    s_nxt.pc_load = 1'b0;
    if (store_off) begin
      s_nxt.dep_key_held = 1'b0;
    end
    case (s_r.state)
      CCR_HALTED: begin
        s_nxt.bus_init = 1'b0;
        if (start_on) begin
          // from halt this is also the unconditional init path
          s_nxt.state = CCR_START_HELD;
          s_nxt.start_from_run = 1'b0;
        end else if (capture_on) begin
          s_nxt.console_addr = console_switch_word;
          // kept apart so later deposits do not move the start address
          s_nxt.start_addr = console_switch_word;
          s_nxt.lights = console_switch_word;
          s_nxt.dep_seen = 1'b0;
        end else if (may_deposit) begin
          s_nxt.console_addr = dep_target;
          s_nxt.dep_seen = 1'b1;
          s_nxt.dep_key_held = 1'b1;
          s_nxt.req.addr = dep_bus_addr;
          s_nxt.req.data = console_switch_word;
          s_nxt.req.write = 1'b1;
          s_nxt.lights = dep_bus_addr;
          s_nxt.state = CCR_DEP_WAIT;
        end else if (resume_off) begin
          s_nxt.run_light = 1'b1;
          if (halt_lvl) begin
            s_nxt.step = 1'b1;
            s_nxt.state = CCR_STEP;
          end else begin
            s_nxt.go = 1'b1;
            s_nxt.state = CCR_RUN;
          end
        end else if (power_up_restart && !halt_lvl) begin
          s_nxt.go = 1'b1;
          s_nxt.run_light = 1'b1;
          s_nxt.state = CCR_RUN;
        end
      end

      // a missing memory never answers done, only the miss pulse
      CCR_DEP_WAIT: begin
        if (bus_nxm) begin
          s_nxt.req.write = 1'b0;
          s_nxt.state = CCR_STUCK;
        end else if (bus_done) begin
          s_nxt.req.write = 1'b0;
          s_nxt.state = CCR_HALTED;
        end
      end

      CCR_STUCK: begin
        // only start in the halt position frees the console
        if (start_on && halt_lvl) begin
          s_nxt.state = CCR_START_HELD;
          s_nxt.start_from_run = 1'b0;
        end
      end

      // peripherals stay in reset for as long as the key is down
      CCR_START_HELD: begin
        s_nxt.bus_init = 1'b1;
        s_nxt.psw_clear = 1'b1;
        s_nxt.pc_load = 1'b1;
        s_nxt.lights = s_r.start_addr;
        s_nxt.dep_seen = 1'b0;
        if (!start_lvl) begin
          s_nxt.bus_init = 1'b0;
          if (halt_lvl) begin
            s_nxt.run_light = 1'b0;
            s_nxt.state = CCR_HALTED;
          end else begin
            s_nxt.run_light = 1'b1;
            s_nxt.go = 1'b1;
            s_nxt.odd_trap = s_r.start_addr[0];
            s_nxt.state = CCR_RUN;
          end
        end
      end

      CCR_RUN: begin
        if (start_on && !lock_lvl) begin
          s_nxt.state = CCR_START_HELD;
          s_nxt.start_from_run = 1'b1;
        end else if (core_halt) begin
          s_nxt.run_light = 1'b0;
          s_nxt.lights = next_pc;
          s_nxt.state = CCR_HALTED;
        end else if (halt_lvl && !lock_lvl) begin
          s_nxt.state = CCR_STOPPING;
        end
      end

      // still running here, so start restarts rather than halts
      CCR_STOPPING: begin
        // traps and interrupts drain before the boundary is taken
        if (start_on && !lock_lvl) begin
          s_nxt.state = CCR_START_HELD;
          s_nxt.start_from_run = 1'b1;
        end else if (stop_ok || core_halt) begin
          s_nxt.run_light = 1'b0;
          s_nxt.lights = next_pc;
          s_nxt.state = CCR_HALTED;
        end else if (!halt_lvl) begin
          s_nxt.state = CCR_RUN;
        end
      end

      CCR_STEP: begin
        if (start_on && !lock_lvl) begin
          s_nxt.state = CCR_START_HELD;
          s_nxt.start_from_run = 1'b1;
        end else if (stop_ok || core_halt) begin
          s_nxt.run_light = 1'b0;
          s_nxt.lights = next_pc;
          s_nxt.state = CCR_HALTED;
        end
      end

      default: begin
        s_nxt.state = CCR_HALTED;
      end
    endcase
    // display swaps to the written word once the key is up
    // a halt or capture after the release must not be overwritten later
    if (show_data) begin
      s_nxt.lights = s_r.req.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.state <= CCR_HALTED;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    lights = s_r.lights;
    run_light = s_r.run_light;
    bus_init = s_r.bus_init;
    psw_clear = s_r.psw_clear;
    pc_load = s_r.pc_load;
    pc_value = s_r.start_addr;
    core_go = s_r.go;
    core_step = s_r.step;
    odd_addr_trap = s_r.odd_trap;
    bus_req = s_r.req.write;
    bus_addr = s_r.req.addr;
    bus_wdata = s_r.req.data;
  end

endmodule
`default_nettype wire

/* File: logic/ccr_pkg.sv */
package ccr_pkg;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] REG_STEP = 16'h0001;
  localparam logic [15:0] GREG_BASE = 16'hFFC0;
  localparam logic [15:0] GREG_MASK = 16'hFFF8;
  localparam logic [15:0] ODD_MASK = 16'hFFFE;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [2:0] SYNC_ZERO = 3'h0;
  localparam int unsigned KEY_STORE = 0;
  localparam int unsigned KEY_CAPTURE = 1;
  localparam int unsigned KEY_RESUME = 2;
  localparam int unsigned KEY_START = 3;
  localparam int unsigned KEY_HALT = 4;
  localparam int unsigned KEY_LOCK = 5;

  typedef enum logic [2:0] {
    CCR_HALTED = 3'b000,
    CCR_START_HELD = 3'b001,
    CCR_RUN = 3'b010,
    CCR_STEP = 3'b011,
    CCR_DEP_WAIT = 3'b100,
    CCR_STUCK = 3'b101,
    CCR_STOPPING = 3'b110
  } ccr_state_e;

  typedef enum logic [1:0] {
    CCR_DISP_NONE = 2'b00,
    CCR_DISP_ADDR = 2'b01,
    CCR_DISP_DATA = 2'b10
  } ccr_disp_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic write;
  } ccr_bus_req_s;

  typedef struct packed {
    logic [2:0] store_sync;
    logic [2:0] capture_sync;
    logic [2:0] resume_sync;
    logic [2:0] start_sync;
    logic [2:0] halt_sync;
    logic [2:0] lock_sync;
    ccr_state_e state;
    logic [5:0] key_lvl;
    logic [15:0] console_addr;
    logic [15:0] start_addr;
    logic [15:0] lights;
    logic dep_seen;
    logic dep_key_held;
    logic start_from_run;
    ccr_bus_req_s req;
    logic run_light;
    logic bus_init;
    logic psw_clear;
    logic pc_load;
    logic go;
    logic step;
    logic odd_trap;
  } ccr_state_s;
endpackage

/* File: test/ccr_console_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module ccr_console_sva import ccr_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] lights,
  input wire logic run_light,
  input wire logic bus_init,
  input wire logic psw_clear,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic core_go,
  input wire logic core_step,
  input wire logic odd_addr_trap,
  input wire logic bus_req,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_done,
  input wire logic bus_nxm
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_dep_go;
    $rose(bus_req);
  endsequence
  sequence s_dep_wait;
    bus_req && !bus_done && !bus_nxm;
  endsequence
  a_init_set: assert property (bus_init |-> psw_clear && pc_load)
    else $error("start hold incomplete");
  a_req_hold: assert property (s_dep_wait |=> bus_req && $stable(bus_addr) && $stable(bus_wdata))
    else $error("write request moved");
  a_req_end: assert property (bus_req && (bus_done || bus_nxm) |=> !bus_req)
    else $error("write request not ended");
  a_dep_halted: assert property (s_dep_go |-> !run_light)
    else $error("write while running");
  a_word_align: assert property (bus_req && ((bus_addr & GREG_MASK) != GREG_BASE) |-> !bus_addr[0])
    else $error("odd memory write");
  a_lights_addr: assert property (s_dep_go |-> ##[0:1] lights == bus_addr)
    else $error("lights not address");
  a_odd_trap: assert property (odd_addr_trap |-> pc_value[0])
    else $error("trap on even start");
  a_go_pulse: assert property (core_go |=> !core_go)
    else $error("go not a pulse");
  a_step_pulse: assert property (core_step |=> !core_step)
    else $error("step not a pulse");
endmodule
`default_nettype wire

/* File: test/ccr_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ccr_core_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic bus_req,
  input wire logic [15:0] bus_addr,
  output logic bus_done,
  output logic bus_nxm,
  output logic instr_boundary,
  output logic [15:0] next_pc
);
  logic [1:0] cnt_r;
  logic miss;
  // 0x8000-0xbfff left unpopulated so a write there answers only with bus_nxm, never bus_done
  assign miss = bus_addr[15:14] == 2'b10;
  assign next_pc = 16'h0100;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 2'h0;
      bus_done <= 1'b0;
      bus_nxm <= 1'b0;
      instr_boundary <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      instr_boundary <= cnt_r == 2'h3;
      bus_done <= bus_req && !bus_done && !bus_nxm && !miss;
      bus_nxm <= bus_req && !bus_done && !bus_nxm && miss;
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top import ccr_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] sw = 16'h0000;
  logic [3:0] keys = 4'h0;
  logic halt_t = 1'b1;
  logic lock = 1'b0;
  logic [15:0] lights, pc_value, bus_addr, bus_wdata, next_pc, a, s, d, st;
  logic run_light, bus_init, psw_clear, pc_load, core_go, core_step, odd_addr_trap, bus_req;
  logic bus_done, bus_nxm, instr_boundary;
  logic trap_p = 1'b0;
  logic odd_seen = 1'b0;
  logic step_seen = 1'b0;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  int failures = 0;
  int checks = 0;
  always #5 clk = ~clk;
  ccr_console u_ccr_console (.clk(clk), .srst(srst), .console_switch_word(sw), .store_key(keys[0]),
    .address_capture_key(keys[1]), .resume_key(keys[2]), .start_key(keys[3]), .halt_toggle(halt_t),
    .console_lockout_position(lock), .power_up_restart(1'b0), .instr_boundary(instr_boundary),
    .trap_pending(trap_p), .next_pc(next_pc), .bus_done(bus_done), .bus_nxm(bus_nxm), .core_halt(1'b0),
    .lights(lights), .run_light(run_light), .bus_init(bus_init), .psw_clear(psw_clear), .pc_load(pc_load),
    .pc_value(pc_value), .core_go(core_go), .core_step(core_step), .odd_addr_trap(odd_addr_trap),
    .bus_req(bus_req), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
  ccr_core_model u_ccr_core_model (.clk(clk), .srst(srst), .bus_req(bus_req), .bus_addr(bus_addr),
    .bus_done(bus_done), .bus_nxm(bus_nxm), .instr_boundary(instr_boundary), .next_pc(next_pc));
  //////////////////////////////
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic down(input int k, input logic [15:0] w);
    @(posedge clk);
    sw <= w;
    keys[k] <= 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic up(input int k);
    @(posedge clk);
    keys[k] <= 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////
  // an unexpected write meets an unknown note and so always mismatches
  always @(negedge clk) begin
    if (bus_req === 1'b1 && (bus_done === 1'b1 || bus_nxm === 1'b1)) begin
      if (exp_q.size() == 0)
        exp_q.push_back(32'hxxxx_xxxx);
      e = exp_q.pop_front();
      cmp(bus_addr, e[31:16]);
      cmp(bus_wdata, e[15:0]);
    end
  end
  always @(negedge clk) begin
    if (odd_addr_trap === 1'b1)
      odd_seen = 1'b1;
    if (core_step === 1'b1)
      step_seen = 1'b1;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial begin
    d = 16'($urandom(65869));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      s = (j == 0) ? {4'h1, 11'($urandom), 1'b0} : (j == 1) ? 16'h2001 : GREG_BASE + REG_STEP;
      a = (j == 2) ? s : s & ODD_MASK;
      st = (j == 2) ? REG_STEP : WORD_STEP;
      down(1, s);
      cmp(lights, s);
      up(1);
      for (int i = 0; i < 2; i++) begin
        d = 16'($urandom);
        exp_q.push_back({a, d});
        down(0, d);
        cmp(lights, a);
        up(0);
        cmp(lights, d);
        a = a + st;
      end
    end
    $display("deposit sequences done");
    @(posedge clk);
    lock <= 1'b1;
    down(0, 16'h1234);
    up(0);
    @(posedge clk);
    lock <= 1'b0;
    exp_q.push_back({a, 16'h5678});
    down(0, 16'h5678);
    up(0);
    $display("lockout done");
    down(1, 16'h0200);
    up(1);
    @(posedge clk);
    halt_t <= 1'b0;
    down(3, 16'h0000);
    cmp({bus_init, psw_clear, pc_load}, 16'h0007);
    cmp(pc_value, 16'h0200);
    up(3);
    cmp(run_light, 1'b1);
    cmp(odd_seen, 1'b0);
    down(0, 16'h4321);
    up(0);
    down(3, 16'h0000);
    cmp(bus_init, 1'b1);
    up(3);
    cmp(run_light, 1'b1);
    @(posedge clk);
    trap_p <= 1'b1;
    halt_t <= 1'b1;
    repeat (20) @(negedge clk);
    cmp(run_light, 1'b1);
    @(posedge clk);
    trap_p <= 1'b0;
    repeat (20) @(negedge clk);
    cmp(run_light, 1'b0);
    down(1, 16'h0500);
    up(1);
    down(2, 16'h0000);
    up(2);
    repeat (4) @(negedge clk);
    cmp(lights, next_pc);
    cmp(run_light, 1'b0);
    cmp(step_seen, 1'b1);
    $display("run control done");
    down(1, 16'h0301);
    up(1);
    @(posedge clk);
    halt_t <= 1'b0;
    down(3, 16'h0000);
    up(3);
    cmp(odd_seen, 1'b1);
    @(posedge clk);
    halt_t <= 1'b1;
    repeat (20) @(negedge clk);
    down(1, 16'h8000);
    up(1);
    exp_q.push_back(32'h8000_00aa);
    down(0, 16'h00aa);
    up(0);
    down(0, 16'h00bb);
    up(0);
    down(3, 16'h0000);
    cmp(bus_init, 1'b1);
    up(3);
    cmp(run_light, 1'b0);
    down(1, 16'h0400);
    up(1);
    exp_q.push_back(32'h0400_00cc);
    down(0, 16'h00cc);
    up(0);
    cmp(16'(exp_q.size()), 16'h0000);
    $display("recovery done");
    end_sim();
  end
endmodule
bind ccr_console ccr_console_sva u_ccr_console_sva (.clk(clk), .srst(srst), .lights(lights),
  .run_light(run_light), .bus_init(bus_init), .psw_clear(psw_clear), .pc_load(pc_load), .pc_value(pc_value),
  .core_go(core_go), .core_step(core_step), .odd_addr_trap(odd_addr_trap), .bus_req(bus_req),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_done(bus_done), .bus_nxm(bus_nxm));
`default_nettype wire
